// ==== rtl/cpsc_pkg.sv ====
package cpsc_pkg;
   localparam logic [11:0] CPSC_DIVIDE_CONTROL_ADDR = 12'h000;
   localparam logic [11:0] CPSC_SLEEP_CONTROL_ADDR  = 12'h004;
   localparam int          CPSC_UNLOCK_BIT          = 7;
   localparam int          CPSC_SLEEP_GATE_BIT      = 0;
   localparam int          CPSC_SLEEP_KIND_LSB      = 1;
   localparam logic [3:0]  CPSC_DIV_RESET_UNPROG    = 4'h0;
   localparam logic [3:0]  CPSC_DIV_RESET_PROG      = 4'h3;
   localparam logic [3:0]  CPSC_DIV_MAX_CODE        = 4'h8;
   localparam logic [3:0]  CPSC_SLEEP_RESET         = 4'h0;
   localparam logic [2:0]  CPSC_UNLOCK_CYCLES       = 3'h4;
   localparam logic [2:0]  CPSC_WAKE_HALT_CYCLES    = 3'h4;
   localparam logic [7:0]  CPSC_STARTUP_CYCLES      = 8'h06;
   localparam logic [7:0]  CPSC_STANDBY_CYCLES      = 8'h06;
   localparam logic [2:0]  CPSC_KIND_IDLE           = 3'h0;
   localparam logic [2:0]  CPSC_KIND_ADC_NR         = 3'h1;
   localparam logic [2:0]  CPSC_KIND_POWER_DOWN     = 3'h2;
   localparam logic [2:0]  CPSC_KIND_POWER_SAVE     = 3'h3;
   localparam logic [2:0]  CPSC_KIND_STANDBY        = 3'h6;

   typedef enum logic [1:0]
   {
      CPSC_RUN   = 2'b00,
      CPSC_SLEEP = 2'b01,
      CPSC_WAKE  = 2'b10,
      CPSC_HALT  = 2'b11
   } cpsc_state_e;
endpackage

// ==== rtl/cpsc_clock_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpsc_clock_control
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   input  wire logic        divide_by_eight_fuse_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        sleep_instr_in,
   input  wire logic        ext_irq_in,
   input  wire logic        int_irq_in,
   input  wire logic        adc_enable_in,
   input  wire logic        sys_reset_in,
   output logic             clk_cpu_en_out,
   output logic             clk_flash_en_out,
   output logic             clk_io_en_out,
   output logic             clk_adc_en_out,
   output logic             osc_enable_out,
   output logic             adc_start_out,
   output logic             cpu_halted_out,
   output logic             reset_vector_out
);
   import cpsc_pkg::*;

   logic [3:0]  divide_select_reg;
   logic [3:0]  active_select_reg;
   logic [3:0]  pending_select_reg;
   logic        pending_reg;
   logic [1:0]  switch_edges_reg;
   logic        unlock_reg;
   logic [2:0]  unlock_cnt_reg;
   logic [3:0]  sleep_control_reg;
   logic [7:0]  div_count_reg;
   logic        div_tick;
   logic        fuse_load_reg;
   cpsc_state_e state_reg;
   logic [2:0]  sleep_kind_reg;
   logic [7:0]  wait_cnt_reg;
   logic        wr_access;
   logic        rd_access;
   logic        hit_div;
   logic        hit_sleep;
   logic        lower_zero;
   logic        unlock_write;
   logic        code_write;
   logic        sleep_legal;
   logic        sleep_entry;
   logic        wake_event;
   logic        in_sleep;
   logic        io_domain_on;
   logic        adc_domain_on;
   logic        osc_domain_on;
   logic [7:0]  startup_cycles;
   logic [7:0]  div_mask;
   logic [31:0] read_word;

   // Bus decode; each access completes in its first access cycle
   assign wr_access  = psel_in & penable_in & pwrite_in & clk_en_in;
   assign rd_access  = psel_in & ~penable_in & ~pwrite_in & clk_en_in;
   assign hit_div    = paddr_in == CPSC_DIVIDE_CONTROL_ADDR;
   assign hit_sleep  = paddr_in == CPSC_SLEEP_CONTROL_ADDR;
   assign lower_zero = pwdata_in[6:0] == 7'h00;

   // Divide register strobes; the unlock pattern must carry zeros in bits 6:0
   assign unlock_write = wr_access & hit_div & pwdata_in[CPSC_UNLOCK_BIT] & lower_zero;
   assign code_write   = wr_access & hit_div & ~pwdata_in[CPSC_UNLOCK_BIT];

   // Sleep entry decode; reserved mode codes never qualify
   assign sleep_legal = (sleep_control_reg[3:1] <= CPSC_KIND_POWER_SAVE) ||
                        (sleep_control_reg[3:1] == CPSC_KIND_STANDBY);
   assign sleep_entry = sleep_instr_in && sleep_control_reg[CPSC_SLEEP_GATE_BIT] && sleep_legal;

   // Wake sources; peripheral interrupts only reach a core whose ADC clock runs
   assign wake_event = ext_irq_in || (int_irq_in && sleep_kind_reg <= CPSC_KIND_ADC_NR);

   // Domains kept alive while asleep; the divided tick still gates the I/O and ADC clocks
   assign in_sleep      = state_reg == CPSC_SLEEP;
   assign io_domain_on  = !in_sleep || sleep_kind_reg == CPSC_KIND_IDLE;
   assign adc_domain_on = !in_sleep || sleep_kind_reg <= CPSC_KIND_ADC_NR;
   assign osc_domain_on = adc_domain_on || sleep_kind_reg == CPSC_KIND_STANDBY;

   // Restart time per mode; idle and noise reduction never stop the oscillator
   always_comb
   begin
      startup_cycles = CPSC_STARTUP_CYCLES;
      if (sleep_kind_reg == CPSC_KIND_STANDBY)
         startup_cycles = CPSC_STANDBY_CYCLES;
      else if (sleep_kind_reg <= CPSC_KIND_ADC_NR)
         startup_cycles = 8'h00;
   end

   // Mask of low count bits that must be zero for a tick; one bit per divider stage
   for (genvar i = 0; i < 8; i++)
   begin : g_mask
      assign div_mask[i] = active_select_reg > 4'(i);
   end

   // Divider counter: one tick per selected period; count never visible
   assign div_tick = (div_count_reg & div_mask) == 8'h00;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         div_count_reg <= 8'h00;
      else if (clk_en_in)
         div_count_reg <= div_count_reg + 8'h01;
   end

   // Fuse is sampled at the first edge after reset release, not in reset
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fuse_load_reg <= 1'b1;
      else if (clk_en_in)
         fuse_load_reg <= 1'b0;
   end

   // Unlock window: set only with bits 6:0 zero; rewrite neither extends nor clears
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         unlock_reg     <= 1'b0;
         unlock_cnt_reg <= 3'h0;
      end
      else if (clk_en_in)
      begin
         if (unlock_write && !unlock_reg)
         begin
            unlock_reg     <= 1'b1;
            unlock_cnt_reg <= CPSC_UNLOCK_CYCLES;
         end
         else if (unlock_reg)
         begin
            if (code_write)
               unlock_reg <= 1'b0;
            else if (unlock_cnt_reg == 3'h1)
               unlock_reg <= 1'b0;
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
         end
      end
   end

   // Divide select: fuse reset value, then unlocked writes only
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         divide_select_reg <= CPSC_DIV_RESET_UNPROG;
      else if (clk_en_in)
      begin
         if (fuse_load_reg)
            divide_select_reg <= divide_by_eight_fuse_in ? CPSC_DIV_RESET_PROG : CPSC_DIV_RESET_UNPROG;
         else if (code_write && unlock_reg)
            divide_select_reg <= pwdata_in[3:0];
      end
   end

   // Switch only on old-period boundary, then after two new-ratio edges
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         active_select_reg  <= CPSC_DIV_RESET_UNPROG;
         pending_select_reg <= CPSC_DIV_RESET_UNPROG;
         pending_reg        <= 1'b0;
         switch_edges_reg   <= 2'h0;
      end
      else if (clk_en_in)
      begin
         // A new request waits until the previous ratio has produced its two edges,
         // so back-to-back writes can never shorten a period below either ratio
         if (!pending_reg && switch_edges_reg == 2'h0 && pending_select_reg != divide_select_reg)
         begin
            pending_select_reg <= divide_select_reg;
            pending_reg        <= 1'b1;
         end
         else if (pending_reg && div_tick)
         begin
            // Reserved codes hold the clock at the slowest rate
            active_select_reg <= (pending_select_reg > CPSC_DIV_MAX_CODE) ? CPSC_DIV_MAX_CODE
                                                                          : pending_select_reg;
            pending_reg       <= 1'b0;
            switch_edges_reg  <= 2'h2;
         end
         else if (div_tick && switch_edges_reg != 2'h0)
            switch_edges_reg <= switch_edges_reg - 2'h1;
      end
   end

   // Sleep control register: gate bit and mode code
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         sleep_control_reg <= CPSC_SLEEP_RESET;
      else if (clk_en_in && wr_access && hit_sleep)
         sleep_control_reg <= pwdata_in[3:0];
   end

   // Sleep sequencer; state is clocked by the undivided clock
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg      <= CPSC_RUN;
         sleep_kind_reg <= CPSC_KIND_IDLE;
         wait_cnt_reg   <= 8'h00;
      end
      else if (clk_en_in)
      begin
         if (sys_reset_in)
            state_reg <= CPSC_RUN;
         else
         begin
            unique case (state_reg)
               CPSC_RUN:
               begin
                  sleep_kind_reg <= sleep_control_reg[3:1];
                  // Reserved codes fall through and the core keeps running
                  if (sleep_entry)
                     state_reg <= CPSC_SLEEP;
               end
               CPSC_SLEEP:
               begin
                  if (wake_event)
                  begin
                     state_reg    <= CPSC_WAKE;
                     wait_cnt_reg <= startup_cycles;
                  end
               end
               CPSC_WAKE:
               begin
                  if (wait_cnt_reg == 8'h00)
                  begin
                     state_reg    <= CPSC_HALT;
                     wait_cnt_reg <= {5'h00, CPSC_WAKE_HALT_CYCLES} - 8'h01;
                  end
                  else
                     wait_cnt_reg <= wait_cnt_reg - 8'h01;
               end
               CPSC_HALT:
               begin
                  if (wait_cnt_reg == 8'h00)
                     state_reg <= CPSC_RUN;
                  else
                     wait_cnt_reg <= wait_cnt_reg - 8'h01;
               end
            endcase
         end
      end
   end

   // Clock enables per domain; the divided tick gates the CPU, flash, I/O and ADC enables
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         clk_cpu_en_out   <= 1'b0;
         clk_flash_en_out <= 1'b0;
         clk_io_en_out    <= 1'b0;
         clk_adc_en_out   <= 1'b0;
         osc_enable_out   <= 1'b1;
         cpu_halted_out   <= 1'b0;
      end
      else if (clk_en_in)
      begin
         clk_cpu_en_out   <= div_tick & (state_reg == CPSC_RUN);
         clk_flash_en_out <= div_tick & (state_reg == CPSC_RUN);
         clk_io_en_out    <= div_tick & io_domain_on;
         clk_adc_en_out   <= div_tick & adc_domain_on;
         osc_enable_out   <= osc_domain_on;
         cpu_halted_out   <= state_reg != CPSC_RUN;
      end
   end

   // One-cycle pulses: ADC start on idle or noise entry, reset vector on reset in sleep
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         adc_start_out    <= 1'b0;
         reset_vector_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         adc_start_out    <= adc_enable_in && state_reg == CPSC_RUN && !sys_reset_in && sleep_entry &&
                             sleep_control_reg[3:1] <= CPSC_KIND_ADC_NR;
         reset_vector_out <= sys_reset_in && state_reg != CPSC_RUN;
      end
   end

   // Read mux; unused divide bits and unmapped space read zero
   always_comb
   begin
      read_word = 32'h0000_0000;
      if (hit_div)
         read_word = {24'h00_0000, unlock_reg, 3'h0, divide_select_reg};
      else if (hit_sleep)
         read_word = {28'h000_0000, sleep_control_reg};
   end

   // APB answer; unmapped addresses read zero and flag an error
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~hit_div & ~hit_sleep;
         if (rd_access)
            prdata_out <= read_word;
      end
   end
endmodule
`default_nettype wire

// ==== test/cpsc_clock_control_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpsc_clock_control_props
   import cpsc_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        sleep_instr_in,
   input wire logic        adc_enable_in,
   input wire logic        sys_reset_in,
   input wire logic        clk_cpu_en_out,
   input wire logic        clk_flash_en_out,
   input wire logic        clk_io_en_out,
   input wire logic        osc_enable_out,
   input wire logic        adc_start_out,
   input wire logic        cpu_halted_out,
   input wire logic        reset_vector_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Halting is only ever caused by a sleep instruction two edges earlier
   a_sleep_needs_instr: assert property ($rose(cpu_halted_out) |-> $past(sleep_instr_in, 2))
      else $error("halt without sleep instruction");
   // CPU and flash clocks always tick together and never while halted
   a_cpu_flash_pair: assert property (clk_cpu_en_out == clk_flash_en_out)
      else $error("cpu and flash enables differ");
   a_halt_stops_cpu: assert property (cpu_halted_out |-> !clk_cpu_en_out)
      else $error("cpu clock ticks while halted");
   // A running CPU clock means the shared divider is feeding I/O too
   a_cpu_implies_io: assert property (clk_cpu_en_out |-> clk_io_en_out)
      else $error("cpu ticks without io tick");
   a_osc_off_quiet: assert property (!osc_enable_out |-> !clk_io_en_out)
      else $error("io clock ticks with oscillator off");
   a_adc_start_cause: assert property (adc_start_out |-> $past(adc_enable_in) ##1 !adc_start_out)
      else $error("adc start without enable or not a pulse");
   a_reset_vector_cause: assert property (reset_vector_out |-> $past(sys_reset_in))
      else $error("reset vector without reset");
   // Wake from interrupt keeps the core halted for five cycles or more
   a_wake_halt_min: assert property ($fell(cpu_halted_out) && !$past(sys_reset_in)
      |-> $past(cpu_halted_out, 5))
      else $error("wake halt too short");
   a_unused_read_zero: assert property (pready_out && !pwrite_in && paddr_in == CPSC_DIVIDE_CONTROL_ADDR
      |-> prdata_out[31:8] == 24'h000000 && prdata_out[6:4] == 3'h0)
      else $error("unused divide bits not zero");
endmodule
bind cpsc_clock_control cpsc_clock_control_props i_props (.clk_in, .rst_n_in, .pwrite_in, .paddr_in,
   .prdata_out, .pready_out, .sleep_instr_in, .adc_enable_in, .sys_reset_in, .clk_cpu_en_out,
   .clk_flash_en_out, .clk_io_en_out, .osc_enable_out, .adc_start_out, .cpu_halted_out, .reset_vector_out);
`default_nettype wire

// ==== test/cpsc_clock_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpsc_clock_control_bench;
   import cpsc_pkg::*;
   logic        clk_in = 0, rst_n_in = 0, fuse = 1, psel = 0, penable = 0, pwrite = 0;
   logic        sleep_instr = 0, ext_irq = 0, int_irq = 0, sys_reset = 0, clk_en = 1, adc_enable = 1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic        pready, pslverr, cpu_en, flash_en, io_en, adc_en, osc_en, adc_start, halted, rvec, e;
   int          num_errors = 0, comparisons = 0, cyc = 0;

   cpsc_clock_control i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
      .divide_by_eight_fuse_in(fuse), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .sleep_instr_in(sleep_instr), .ext_irq_in(ext_irq), .int_irq_in(int_irq), .adc_enable_in(adc_enable),
      .sys_reset_in(sys_reset), .clk_cpu_en_out(cpu_en), .clk_flash_en_out(flash_en), .clk_io_en_out(io_en),
      .clk_adc_en_out(adc_en), .osc_enable_out(osc_en), .adc_start_out(adc_start), .cpu_halted_out(halted),
      .reset_vector_out(rvec));

   initial
   begin
      forever #50 clk_in = ~clk_in;
   end

   // Cycle count doubles as the hang guard; the full run needs about 2500 cycles
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         num_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; waits up to 50 cycles for pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits for the next divided I/O tick, bounded, returning its cycle number
   task automatic io_tick(input int lim, output int at, output logic ok);
      int n;
      n = 0;
      do begin @(posedge clk_in); n++; end while (io_en !== 1'b1 && n < lim);
      at = cyc;
      ok = (io_en === 1'b1);
   endtask

   task automatic t_reset_and_map();
      apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0); check("div reset", q, 32'h00000003);
      apb(1'b0, CPSC_SLEEP_CONTROL_ADDR, 32'h0); check("sleep reset", q, 32'h00000000);
      apb(1'b0, 12'h008, 32'h0); check("unmapped data", q, 32'h00000000);
      check("unmapped err", e, 32'h00000001);
   endtask

   // An unlock pattern with bits 6:0 set is ignored; the unlock window lasts four cycles and is not extended
   task automatic t_unlock();
      apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h85); apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0);
      check("locked write", q, 32'h00000003);
      apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h80); apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0);
      check("unlock set", q, 32'h00000083);
      repeat (4) @(posedge clk_in);
      apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0); check("unlock expired", q, 32'h00000003);
      apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h80); apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h80);
      apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0); check("no extension", q, 32'h00000003);
   endtask

   // Every legal code, each period measured once after two settling ticks
   task automatic t_divide_codes();
      int a, b;
      logic ok;
      for (int c = 0; c <= 8; c++)
      begin
         apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h80); apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, c);
         apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0); check("div code", q, c);
         repeat (2) io_tick(600, a, ok);
         io_tick(600, a, ok); io_tick(600, b, ok);
         check("div period", b - a, 32'h1 << c);
      end
      // A frozen clock enable must also freeze the unlock window
      apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h80);
      clk_en <= 1'b0;
      repeat (8) @(posedge clk_in);
      clk_en <= 1'b1;
      apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h2); apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0);
      check("frozen window", q, 32'h00000002);
      apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h80); apb(1'b1, CPSC_DIVIDE_CONTROL_ADDR, 32'h0);
      // The slow old ratio must finish before sleep tests sample single-cycle ticks
      repeat (300) @(posedge clk_in);
   endtask

   task automatic enter(input logic [2:0] kind, input logic gate, output logic adc_seen);
      apb(1'b1, CPSC_SLEEP_CONTROL_ADDR, {kind, gate});
      @(posedge clk_in); sleep_instr <= 1'b1;
      @(posedge clk_in); sleep_instr <= 1'b0;
      adc_seen = 1'b0;
      repeat (3) begin @(posedge clk_in); adc_seen |= (adc_start === 1'b1); end
   endtask

   // All eight kind codes: reserved ones and a cleared gate must not halt
   task automatic t_sleep_kinds();
      int t0, n;
      logic ok, adc_seen, valid;
      enter(3'h0, 1'b0, adc_seen); check("gate off", halted, 1'b0);
      for (int k = 0; k < 8; k++)
      begin
         valid = (k inside {0, 1, 2, 3, 6});
         enter(k[2:0], 1'b1, adc_seen); check("halted", halted, valid);
         if (valid)
         begin
            check("osc", osc_en, k inside {0, 1, 6});
            check("adc clk", adc_en, k < 2);
            check("cpu clk", cpu_en, 1'b0);
            check("adc start", adc_seen, k < 2);
            io_tick(8, t0, ok); check("io in sleep", ok, k == 0);
            if (k == 0) int_irq <= 1'b1; else ext_irq <= 1'b1;
            n = 0;
            do begin @(posedge clk_in); n++; end while (halted !== 1'b0 && n < 50);
            check("wake halt", n >= ((k > 1) ? 10 : 4), 1'b1);
            int_irq <= 1'b0; ext_irq <= 1'b0;
         end
         apb(1'b1, CPSC_SLEEP_CONTROL_ADDR, 32'h0);
      end
   endtask

   task automatic t_reset_in_sleep();
      logic adc_seen, hit;
      for (int i = 0; i < 2; i++)
      begin
         adc_enable <= (i != 0);
         enter((i == 0) ? CPSC_KIND_IDLE : CPSC_KIND_POWER_DOWN, 1'b1, adc_seen);
         check("adc start off", adc_seen, 1'b0);
         @(posedge clk_in); sys_reset <= 1'b1;
         @(posedge clk_in); sys_reset <= 1'b0;
         hit = 1'b0;
         repeat (3) begin @(posedge clk_in); hit |= (rvec === 1'b1); end
         check("reset vector", hit, 1'b1);
         check("reset wakes", halted, 1'b0);
      end
      adc_enable <= 1'b1;
   endtask

   // Mid-run reset with the fuse unprogrammed loads the undivided code
   task automatic t_fuse_reset();
      fuse <= 1'b0;
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      check("osc in reset", osc_en, 1'b1);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      apb(1'b0, CPSC_DIVIDE_CONTROL_ADDR, 32'h0); check("div reset unprog", q, 32'h00000000);
   endtask

   initial
   begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      t_reset_and_map();
      t_unlock();
      t_divide_codes();
      t_sleep_kinds();
      t_reset_in_sleep();
      t_fuse_reset();
      stop_test();
   end
endmodule
`default_nettype wire
